// [rtl/vac_pkg.sv]
// shared constants for the video converter output stream and configuration port
package vac_pkg;
    // data stream shape
    localparam int          WORD_W           = 16;              // one conversion result
    localparam int          BEAT_W           = 2;               // bits per beat
    localparam int          BEATS            = 8;               // beats per result
    localparam int          FIFO_DEPTH       = 8;               // words buffered ahead of the serialiser
    localparam logic [2:0]  LAST_BEAT        = 3'h7;            // index of the final beat
    localparam logic [2:0]  FIRST_BEAT       = 3'h0;            // index of the start beat
    localparam logic [2:0]  PRE_START_SINGLE = 3'h7;            // rise before start, single-edge mode
    localparam logic [2:0]  PRE_START_DOUBLE = 3'h6;            // rise before start, double-edge mode
    localparam logic [3:0]  WORD_BEATS_M1    = 4'h7;            // captured beats before the last one
    // output code limits, straight binary
    localparam logic [15:0] CODE_BLACK       = 16'h0000;
    localparam logic [15:0] CODE_WHITE       = 16'hFFFF;
    // configuration frame: 8 address bits then 8 data bits, msb first
    localparam logic [4:0]  CFG_FRAME_BITS   = 5'h10;
    localparam logic [4:0]  CFG_LAST_BIT     = 5'h0F;
    localparam logic [7:0]  ADDR_OFFSET      = 8'h00;           // 8-bit black-level offset code
    localparam logic [7:0]  ADDR_GAIN        = 8'h01;           // 6-bit gain code
    localparam logic [7:0]  ADDR_MODE        = 8'h02;           // clock and input mode bits
    localparam int          MODE_BIT_DOUBLE  = 0;               // 1: double-edge clock mode
    localparam int          MODE_BIT_CDS     = 1;               // 1: correlated double sampling input
    // setting reset values
    localparam logic [7:0]  OFFSET_RST       = 8'h00;
    localparam logic [5:0]  GAIN_RST         = 6'h00;
    // gain and offset arithmetic
    localparam logic [6:0]  GAIN_UNITY       = 7'h10;           // gain code 0 multiplies by one
    localparam int          GAIN_SHIFT       = 4;
    localparam int          OFFSET_SHIFT     = 6;               // log2 of the offset lsb weight, in codes before gain
    // timing
    localparam int          CLK_HZ           = 40_000_000;
    localparam int          MAX_SPS          = 5_000_000;       // highest pixel rate
    localparam int          MIN_PIXEL_CLKS   = (CLK_HZ + MAX_SPS - 1) / MAX_SPS;
    localparam logic [7:0]  MCLK_HALF_CLKS   = 8'h04;           // main clock half period in clk cycles
    localparam logic [7:0]  CFG_HALF_CLKS    = 8'h04;           // serial clock half period in clk cycles
    localparam logic [7:0]  GAP_CLKS         = 8'h02;           // turnaround before driving
endpackage

// [rtl/vac_if.sv]
// link between the converter end and the controller end, with the shared data pins resolved
interface vac_if;
    logic mclk;                 // main clock, made by the controller
    logic sample_timing_pulse;  // one pulse per pixel period
    logic reset_n;              // converter reset, active low
    logic serial_enable_n;      // low: pins are the configuration port
    // lower data pin, doubles as cfg_serial_clock
    logic out_bit_low_dev_o;
    logic out_bit_low_dev_oe_n;
    logic cfg_serial_clock_o;
    logic cfg_serial_clock_oe_n;
    // upper data pin, doubles as cfg_serial_data
    logic out_bit_high_dev_o;
    logic out_bit_high_dev_oe_n;
    logic cfg_serial_data_o;
    logic cfg_serial_data_oe_n;
    // resolved wire levels, pull-down when nobody drives
    logic pin_low;
    logic pin_high;

    assign pin_low  = !out_bit_low_dev_oe_n  ? out_bit_low_dev_o  :
                      !cfg_serial_clock_oe_n ? cfg_serial_clock_o : 1'b0;
    assign pin_high = !out_bit_high_dev_oe_n ? out_bit_high_dev_o :
                      !cfg_serial_data_oe_n  ? cfg_serial_data_o  : 1'b0;

    modport dev (
        input  mclk, sample_timing_pulse, reset_n, serial_enable_n, pin_low, pin_high,
        output out_bit_low_dev_o, out_bit_low_dev_oe_n, out_bit_high_dev_o, out_bit_high_dev_oe_n
    );
    modport ctl (
        input  pin_low, pin_high,
        output mclk, sample_timing_pulse, reset_n, serial_enable_n,
               cfg_serial_clock_o, cfg_serial_clock_oe_n, cfg_serial_data_o, cfg_serial_data_oe_n
    );
endinterface

// [rtl/vac_device.sv]
// converter end: result buffer, gain/offset correction, 2-bit stream serialiser and write-only config port

// fifo with registered full/empty flags
module vac_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // filling side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // draining side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_q;    // write pointer
        logic [AW-1:0] rd_q;    // read pointer
        logic [AW:0]   cnt_q;   // words held
        logic          full_q;  // no room left
        logic          empty_q; // nothing held
    } vac_fifo_state_type;

    vac_fifo_state_type s;
    vac_fifo_state_type n;
    logic [WIDTH-1:0]   mem [DEPTH];    // storage words
    logic               push;
    logic               pop;

    assign push      = in_valid && !s.full_q;
    assign pop       = out_ready && !s.empty_q;
    assign in_ready  = !s.full_q;
    assign out_valid = !s.empty_q;
    assign out_data  = mem[s.rd_q];

    // pointer and count update, synchronous reset
    always_comb begin
        n = s;
        if (push) begin
            n.wr_q = (s.wr_q == AW'(DEPTH - 1)) ? '0 : s.wr_q + 1'b1;
        end
        if (pop) begin
            n.rd_q = (s.rd_q == AW'(DEPTH - 1)) ? '0 : s.rd_q + 1'b1;
        end
        n.cnt_q   = s.cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        n.full_q  = (n.cnt_q == (AW+1)'(DEPTH));
        n.empty_q = (n.cnt_q == '0);
        if (!nrst) begin
            n         = '0;
            n.empty_q = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        s <= n;
    end

    // storage write, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[s.wr_q] <= in_data;
        end
    end
endmodule

// converter digital end
module vac_device (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // link to the controller
    vac_if.dev               link,
    // raw conversion results from the sampling core
    input  wire logic [15:0] conv_data,
    input  wire logic        conv_valid,
    output logic             conv_ready,
    // current settings for the analog front end
    output logic [7:0]       offset_code,
    output logic [5:0]       gain_code,
    output logic             double_edge_mode,
    output logic             cds_mode
);
    typedef struct packed {
        logic        mclk_q;        // main clock last seen
        logic        seen_q;        // a rise saw the timing pulse high
        logic [15:0] shift_q;       // remaining bit pairs of the word in flight
        logic [2:0]  beat_q;        // beat index of the word in flight
        logic        active_q;      // word in flight
        logic        hi_q;          // upper beat bit on the pin
        logic        lo_q;          // lower beat bit on the pin
        logic        oe_n_q;        // pin drivers off
        logic        sclk_q;        // serial clock last seen
        logic [15:0] cfg_sh_q;      // incoming frame
        logic [4:0]  cfg_cnt_q;     // frame bits received
        logic [7:0]  offset_q;      // offset code
        logic [5:0]  gain_q;        // gain code
        logic        dbl_q;         // double-edge mode
        logic        cds_q;         // cds input mode
    } vac_dev_state_type;

    vac_dev_state_type  s;
    vac_dev_state_type  n;
    logic               rst;        // module reset or reset pin
    logic               rise;       // main clock rising
    logic               fall;       // main clock falling
    logic               launch;     // edge that moves a beat
    logic               start;      // effective sampling instant
    logic               sclk_rise;  // configuration clock rising
    logic [15:0]        in_lvl;     // polarity-corrected sample
    logic signed [19:0] lvl;        // level after offset
    logic signed [26:0] gfac;       // gain factor, sixteenths
    logic signed [26:0] amp;        // level after gain
    logic [15:0]        corrected;  // clipped output code
    logic [15:0]        buf_data;
    logic               buf_valid;
    logic               buf_ready;  // buffer has room
    logic [15:0]        frame;

    assign rst = !nrst || !link.reset_n;

    // sample correction ahead of the buffer
    always_comb begin
        in_lvl = s.cds_q ? ~conv_data : conv_data;
        lvl    = signed'({4'h0, in_lvl}) + (20'(signed'(s.offset_q)) <<< vac_pkg::OFFSET_SHIFT);
        gfac   = signed'(27'({1'b0, s.gain_q} + vac_pkg::GAIN_UNITY));
        amp    = (27'(lvl) * gfac) >>> vac_pkg::GAIN_SHIFT;
        // clip to the straight binary range
        if (amp < 0) begin
            corrected = vac_pkg::CODE_BLACK;
        end else if (amp > 27'(vac_pkg::CODE_WHITE)) begin
            corrected = vac_pkg::CODE_WHITE;
        end else begin
            corrected = amp[15:0];
        end
    end

    // edge detection on the synchronous link inputs
    assign rise      = link.mclk && !s.mclk_q;
    assign fall      = !link.mclk && s.mclk_q;
    assign launch    = rise || (s.dbl_q && fall);
    assign start     = rise && !link.sample_timing_pulse && s.seen_q;
    assign sclk_rise = link.pin_low && !s.sclk_q;
    assign frame     = {s.cfg_sh_q[14:0], link.pin_high};

    // buffer between the sampling core and the serialiser
    vac_fifo #(
        .WIDTH (vac_pkg::WORD_W),
        .DEPTH (vac_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .nrst      (!rst),
        .in_data   (corrected),
        .in_valid  (conv_valid),
        .in_ready  (buf_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (start)
    );

    // next state: serialiser, pin drive and configuration receiver
    always_comb begin
        n            = s;
        n.mclk_q     = link.mclk;
        n.sclk_q     = link.pin_low;
        // last rise with the pulse high arms the next start
        if (rise) begin
            n.seen_q = link.sample_timing_pulse ? 1'b1 : (start ? 1'b0 : s.seen_q);
        end
        if (start) begin
            // an empty buffer sends an all-zero word
            n.shift_q  = buf_valid ? {buf_data[13:0], 2'b00} : {s.shift_q[13:0], 2'b00};
            n.hi_q     = buf_valid ? buf_data[15] : s.shift_q[15];
            n.lo_q     = buf_valid ? buf_data[14] : s.shift_q[14];
            n.beat_q   = vac_pkg::FIRST_BEAT;
            n.active_q = 1'b1;
        end else if (launch && s.active_q) begin
            n.hi_q     = s.shift_q[15];
            n.lo_q     = s.shift_q[14];
            n.shift_q  = {s.shift_q[13:0], 2'b00};
            n.beat_q   = s.beat_q + 1'b1;
            n.active_q = (n.beat_q != vac_pkg::LAST_BEAT);
        end
        // pin ownership follows the enable
        n.oe_n_q = !link.serial_enable_n ? 1'b1 : 1'b0;
        if (link.serial_enable_n) begin
            n.cfg_cnt_q = '0;
        end else if (sclk_rise && s.oe_n_q) begin
            // only rises after this end let go count, our own last beat is no clock
            n.cfg_sh_q  = frame;
            n.cfg_cnt_q = s.cfg_cnt_q + 1'b1;
            // a full frame updates the settings its address names, unknown addresses none
            if (s.cfg_cnt_q == vac_pkg::CFG_LAST_BIT) begin
                n.cfg_cnt_q = '0;
                unique case (frame[15:8])
                    vac_pkg::ADDR_OFFSET: n.offset_q = frame[7:0];
                    vac_pkg::ADDR_GAIN:   n.gain_q   = frame[5:0];
                    vac_pkg::ADDR_MODE: begin
                        n.dbl_q = frame[vac_pkg::MODE_BIT_DOUBLE];
                        n.cds_q = frame[vac_pkg::MODE_BIT_CDS];
                    end
                    default: begin
                        n.cfg_sh_q = frame;   // unknown address ignored
                    end
                endcase
            end
        end
        if (rst) begin
            n            = '0;
            n.oe_n_q     = 1'b1;
            n.offset_q   = vac_pkg::OFFSET_RST;
            n.gain_q     = vac_pkg::GAIN_RST;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        s <= n;
    end

    // room flag is the buffer's own registered flag, so a take never meets a full buffer
    assign conv_ready = buf_ready;

    // outputs straight from state
    assign link.out_bit_high_dev_o    = s.hi_q;
    assign link.out_bit_low_dev_o     = s.lo_q;
    assign link.out_bit_high_dev_oe_n = s.oe_n_q;
    assign link.out_bit_low_dev_oe_n  = s.oe_n_q;
    assign offset_code                = s.offset_q;
    assign gain_code                  = s.gain_q;
    assign double_edge_mode           = s.dbl_q;
    assign cds_mode                   = s.cds_q;
endmodule

// [rtl/vac_controller.sv]
// controller end: main clock and timing pulse generator, stream receiver, configuration writer
module vac_controller (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // link to the converter
    vac_if.ctl               link,
    // configuration write requests
    input  wire logic        cfg_valid,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [7:0]  cfg_data,
    output logic             cfg_ready,
    // received results
    output logic [15:0]      word_data,
    output logic             word_valid
);
    typedef enum logic [3:0] {
        C_IDLE  = 4'b0001,  // pins owned by the converter
        C_LEAD  = 4'b0010,  // enable low, waiting for release
        C_SHIFT = 4'b0100,  // clocking the frame out
        C_TAIL  = 4'b1000   // released, enable about to rise
    } vac_cfg_state_type;

    typedef struct packed {
        vac_cfg_state_type st_q;
        logic [7:0]  div_q;     // main clock divider
        logic        mclk_q;
        logic [2:0]  phase_q;   // index of the next launch edge
        logic        sample_timing_pulse_q;
        logic        dbl_q;     // mirrors the converter clock mode
        logic [15:0] rx_q;      // beats collected
        logic [3:0]  rx_cnt_q;  // beats since the last start
        logic [15:0] word_q;
        logic        wvalid_q;
        logic        skip_q;    // drop the word spoiled by a frame
        logic [15:0] tx_q;      // frame bits left
        logic [4:0]  bits_q;    // frame rises made
        logic [7:0]  cdiv_q;    // serial clock divider
        logic        sclk_q;
        logic        sen_n_q;
        logic        drv_n_q;   // pin drivers off
        logic        rstn_q;
        logic        rdy_q;
    } vac_ctl_state_type;

    vac_ctl_state_type s;
    vac_ctl_state_type n;
    logic              tick;    // main clock toggles now
    logic              up;      // toggle is a rise
    logic              launch;  // toggle moves a beat
    logic              pre;     // rise ahead of the start edge
    logic              ctick;   // serial clock toggles now

    // 8 launch edges per pixel, over 8 or 4 main clock periods by mode
    assign tick   = (s.div_q == vac_pkg::MCLK_HALF_CLKS - 8'h01);
    assign up     = !s.mclk_q;
    assign launch = tick && (up || s.dbl_q);
    // after a mode change rises may sit on odd phases in double mode, so phase 7 also counts there
    assign pre    = up && (s.dbl_q ? (s.phase_q >= vac_pkg::PRE_START_DOUBLE) :
                                     (s.phase_q == vac_pkg::PRE_START_SINGLE));
    assign ctick  = (s.cdiv_q == vac_pkg::CFG_HALF_CLKS - 8'h01);

    // next state
    always_comb begin
        n          = s;
        n.wvalid_q = 1'b0;
        n.rstn_q   = 1'b1;
        n.div_q    = tick ? '0 : s.div_q + 8'h01;
        if (tick) begin
            n.mclk_q = !s.mclk_q;
            // pulse high over exactly one rise per pixel
            n.sample_timing_pulse_q = pre;
        end
        if (launch) begin
            // sample the beat launched at the previous launch edge
            // the pulse rise realigns the count so that the start rise is phase 0
            n.phase_q = (pre && s.dbl_q) ? vac_pkg::LAST_BEAT : s.phase_q + 1'b1;
            n.rx_q    = {s.rx_q[13:0], link.pin_high, link.pin_low};
            n.rx_cnt_q = (s.rx_cnt_q == 4'hF) ? s.rx_cnt_q : s.rx_cnt_q + 4'h1;
            if (s.phase_q == vac_pkg::FIRST_BEAT) begin
                n.rx_cnt_q = '0;
                // the word before the first start after reset is stale, drop it too
                n.skip_q   = !s.st_q[0] || (s.rx_cnt_q == '1);
                if (s.rx_cnt_q == vac_pkg::WORD_BEATS_M1 && !s.skip_q && s.st_q == C_IDLE) begin
                    n.word_q   = n.rx_q;
                    n.wvalid_q = 1'b1;
                end
            end
        end
        n.cdiv_q = ctick ? '0 : s.cdiv_q + 8'h01;
        unique case (s.st_q)
            C_IDLE: begin
                if (cfg_valid && s.rdy_q) begin
                    n.tx_q    = {cfg_addr, cfg_data};
                    n.sen_n_q = 1'b0;
                    n.rdy_q   = 1'b0;
                    n.skip_q  = 1'b1;
                    n.cdiv_q  = '0;
                    n.st_q    = C_LEAD;
                    if (cfg_addr == vac_pkg::ADDR_MODE) begin
                        n.dbl_q = cfg_data[vac_pkg::MODE_BIT_DOUBLE];
                    end
                end
            end
            C_LEAD: begin
                // converter lets go before this end drives
                if (s.cdiv_q == vac_pkg::GAP_CLKS) begin
                    n.drv_n_q = 1'b0;
                    n.sclk_q  = 1'b0;
                    n.bits_q  = '0;
                    n.cdiv_q  = '0;
                    n.st_q    = C_SHIFT;
                end
            end
            C_SHIFT: begin
                if (ctick) begin
                    n.sclk_q = !s.sclk_q;
                    if (!s.sclk_q) begin
                        n.bits_q = s.bits_q + 5'h01;
                    end else begin
                        n.tx_q = {s.tx_q[14:0], 1'b0};
                        if (s.bits_q == vac_pkg::CFG_FRAME_BITS) begin
                            n.drv_n_q = 1'b1;
                            n.st_q    = C_TAIL;
                        end
                    end
                end
            end
            C_TAIL: begin
                if (ctick) begin
                    n.sen_n_q = 1'b1;
                    n.rdy_q   = 1'b1;
                    n.st_q    = C_IDLE;
                end
            end
        endcase
        if (!nrst) begin
            n         = '0;
            n.st_q    = C_IDLE;
            n.sen_n_q = 1'b1;
            n.drv_n_q = 1'b1;
            n.skip_q  = 1'b1;
            n.rdy_q   = 1'b1;
            n.rx_cnt_q = '1;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        s <= n;
    end

    // outputs straight from state
    assign link.mclk                  = s.mclk_q;
    assign link.sample_timing_pulse   = s.sample_timing_pulse_q;
    assign link.reset_n               = s.rstn_q;
    assign link.serial_enable_n       = s.sen_n_q;
    assign link.cfg_serial_clock_o    = s.sclk_q;
    assign link.cfg_serial_data_o     = s.tx_q[15];
    assign link.cfg_serial_clock_oe_n = s.drv_n_q;
    assign link.cfg_serial_data_oe_n  = s.drv_n_q;
    assign cfg_ready                  = s.rdy_q;
    assign word_data                  = s.word_q;
    assign word_valid                 = s.wvalid_q;
endmodule

// [test/vac_chk.sv]
// link checker for the converter and controller ends
module vac_chk (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // link signals
    input wire logic mclk,
    input wire logic sample_timing_pulse,
    input wire logic reset_n,
    input wire logic serial_enable_n,
    input wire logic out_bit_low_dev_o,
    input wire logic out_bit_low_dev_oe_n,
    input wire logic out_bit_high_dev_oe_n,
    input wire logic cfg_serial_clock_oe_n
);
    logic       tp_q;  // pulse one cycle ago
    logic       mk_q;  // main clock one cycle ago
    logic [1:0] tog_q; // recent main clock toggles
    logic [7:0] gap_q; // cycles since the pulse rose
    // toggle history and pulse spacing
    always_ff @(posedge clk) begin
        tp_q  <= sample_timing_pulse;
        mk_q  <= mclk;
        tog_q <= {tog_q[0], mclk != mk_q};
        if (!nrst) gap_q <= 8'hFF;
        else if (sample_timing_pulse && !tp_q) gap_q <= 8'h00;
        else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_cfg_release: assert property (!serial_enable_n [*3] |-> out_bit_low_dev_oe_n && out_bit_high_dev_oe_n)
        else $error("pins driven during configuration");
    a_data_drive: assert property ((serial_enable_n && reset_n) [*3] |-> !out_bit_low_dev_oe_n && !out_bit_high_dev_oe_n)
        else $error("data pins not driven");
    a_no_clash: assert property (out_bit_low_dev_oe_n || cfg_serial_clock_oe_n)
        else $error("two drivers on the lower pin");
    a_cfg_gated: assert property (!cfg_serial_clock_oe_n |-> !serial_enable_n)
        else $error("serial clock driven outside configuration");
    a_beat_launch: assert property (!out_bit_low_dev_oe_n && $stable(out_bit_low_dev_oe_n) && $changed(out_bit_low_dev_o) |-> (mclk != mk_q) || tog_q != 2'b00)
        else $error("beat changed away from a main clock edge");
    a_pulse_shape: assert property ($rose(sample_timing_pulse) |-> $rose(mclk) ##0 sample_timing_pulse [*4] ##1 !sample_timing_pulse)
        else $error("timing pulse shape wrong");
    a_pixel_rate: assert property (sample_timing_pulse && !tp_q |-> gap_q >= 8'h07)
        else $error("pixel rate too high");
    a_reset_release: assert property (!reset_n |=> out_bit_low_dev_oe_n && out_bit_high_dev_oe_n)
        else $error("pins driven in reset");
endmodule

// [test/tb_top.sv]
// self-checking bench joining both link ends
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, nrst = 1'b0, run = 1'b0, tk;
    logic        conv_valid = 1'b0, cfg_valid = 1'b0;
    logic [15:0] conv_data = 16'h0000;
    logic [7:0]  cfg_addr = 8'h00, cfg_data = 8'h00, offset_code;
    logic        conv_ready, cfg_ready, word_valid, double_edge_mode, cds_mode;
    logic [15:0] word_data;
    logic [5:0]  gain_code;
    logic [15:0] cur_s = 16'h0000, old_s = 16'h0000; // expected {double, cds, gain, offset}
    logic [15:0] q[$];                              // results taken by the converter
    int          fails = 0, cmp_count = 0, rcv = 0;
    logic [15:0] tbl [10] = '{16'h007F, 16'h013F, 16'h0080, 16'h05AA, 16'h0201,
                              16'h0202, 16'h0203, 16'h0121, 16'h0000, 16'h0200};
    vac_if vac_if_inst();
    vac_device vac_device_inst (.clk(clk), .nrst(nrst), .link(vac_if_inst), .conv_data(conv_data),
        .conv_valid(conv_valid), .conv_ready(conv_ready), .offset_code(offset_code), .gain_code(gain_code),
        .double_edge_mode(double_edge_mode), .cds_mode(cds_mode));
    vac_controller vac_controller_inst (.clk(clk), .nrst(nrst), .link(vac_if_inst), .cfg_valid(cfg_valid),
        .cfg_addr(cfg_addr), .cfg_data(cfg_data), .cfg_ready(cfg_ready), .word_data(word_data), .word_valid(word_valid));
    vac_chk vac_chk_inst (.clk(clk), .nrst(nrst), .mclk(vac_if_inst.mclk),
        .sample_timing_pulse(vac_if_inst.sample_timing_pulse), .reset_n(vac_if_inst.reset_n),
        .serial_enable_n(vac_if_inst.serial_enable_n), .out_bit_low_dev_o(vac_if_inst.out_bit_low_dev_o),
        .out_bit_low_dev_oe_n(vac_if_inst.out_bit_low_dev_oe_n),
        .out_bit_high_dev_oe_n(vac_if_inst.out_bit_high_dev_oe_n),
        .cfg_serial_clock_oe_n(vac_if_inst.cfg_serial_clock_oe_n));
    always #12.5 clk = ~clk;
    // corrected code of a raw result, clipped to the code range
    function automatic logic [15:0] fix(logic [15:0] x, logic [15:0] s);
        logic [15:0] y;
        int          v;
        y = s[14] ? ~x : x;
        v = (int'(y) + 64 * int'($signed(s[7:0]))) * (16 + int'(s[13:8])) / 16;
        return v < 0 ? 16'h0000 : v > 32'h0000_FFFF ? 16'hFFFF : 16'(v);
    endfunction
    task automatic check(string n, logic [15:0] s, logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // one configuration frame, then the expected settings follow it
    task automatic cfg_write(logic [15:0] w);
        @(posedge clk);
        #2 {cfg_valid, cfg_addr, cfg_data} = {1'b1, w};
        @(posedge clk);
        #2 cfg_valid = 1'b0;
        repeat (400) begin
            @(posedge clk);
            if (cfg_ready === 1'b1) break;
        end
        #2 check("cfg_ready", 16'(cfg_ready), 16'h0001);
        old_s = cur_s;
        case (w[15:8])
            vac_pkg::ADDR_OFFSET: cur_s[7:0] = w[7:0];
            vac_pkg::ADDR_GAIN: cur_s[13:8] = w[5:0];
            vac_pkg::ADDR_MODE: cur_s[15:14] = {w[vac_pkg::MODE_BIT_DOUBLE], w[vac_pkg::MODE_BIT_CDS]};
            default: ;
        endcase
    endtask
    // result source holds each value until the buffer takes it; corners 0000 and ffff among random codes
    always @(posedge clk) begin
        tk = conv_valid && conv_ready && nrst;
        if (tk) q.push_back(conv_data);
        #2;
        if (tk || !conv_valid || !run) begin
            conv_valid = run && ($urandom % 4 != 0);
            conv_data = ($urandom % 8 == 0) ? {16{$urandom % 2 == 1}} : 16'($urandom);
        end
    end
    // each received word must be one of the next results sent, skipped ones dropped
    always @(posedge clk) begin
        int k;
        k = -1;
        if (word_valid === 1'b1) begin
            rcv++;
            for (int i = 0; i < 10 && i < q.size(); i++)
                if (k < 0 && (fix(q[i], cur_s) === word_data || fix(q[i], old_s) === word_data)) k = i;
            check("word_data", 16'(k >= 0), 16'h0001);
            for (int i = 0; i <= k; i++) void'(q.pop_front());
        end
    end
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h0f11));
        repeat (3) @(posedge clk);
        #2 nrst = 1'b1;
        repeat (4) @(posedge clk);
        #2 run = 1'b1;
        check("settings", {double_edge_mode, cds_mode, gain_code, offset_code}, cur_s);
        check("conv_ready", 16'(conv_ready), 16'h0001);
        repeat (1500) @(posedge clk);
        $display("test stream done");
        foreach (tbl[i]) begin
            cfg_write(tbl[i]);
            check("settings", {double_edge_mode, cds_mode, gain_code, offset_code}, cur_s);
            repeat (700) @(posedge clk);
        end
        $display("test settings done");
        #2 {nrst, run} = 2'b00;
        repeat (3) @(posedge clk);
        #2 q.delete();
        {cur_s, old_s} = 32'h0000_0000;
        check("settings", {double_edge_mode, cds_mode, gain_code, offset_code}, cur_s);
        nrst = 1'b1;
        repeat (4) @(posedge clk);
        #2 run = 1'b1;
        repeat (1000) @(posedge clk);
        check("word count", 16'(rcv > 60), 16'h0001);
        $display("test reset done");
        stop_test();
    end
endmodule
